// >>> logic/sfil_regs.vh
// register offsets, field positions and timing counts of the status logic
`ifndef SFIL_REGS_VH
`define SFIL_REGS_VH
`define SFIL_NCOND        8
// printed offsets are register indices; byte address is index times four
`define SFIL_IDX_CFG      16'h0400
`define SFIL_IDX_SEL      16'h0401
`define SFIL_IDX_IE       16'h0402
`define SFIL_IDX_HIZ      16'h0403
`define SFIL_IDX_LIVE     16'h0404
`define SFIL_IDX_LATCH    16'h0405
`define SFIL_IDX_FATAL    16'h0406
`define SFIL_ADR_W        18
`define SFIL_CFG_FILT_LSB 0
`define SFIL_CFG_FILT_MSB 2
`define SFIL_CFG_LONG     3
`define SFIL_FAT_CHK      0
`define SFIL_FAT_2BIT     1
`define SFIL_FAT_INT      2
`define SFIL_BIT_OFLOW    0
`define SFIL_BIT_FALARM   1
`define SFIL_BIT_LAGLIM   2
`define SFIL_BIT_INCLIM   3
`define SFIL_BIT_LAGFATL  4
`define SFIL_BIT_SCAMP    5
`define SFIL_BIT_ADAPT    6
`define SFIL_BIT_RES      7
`define SFIL_CLK_MHZ      100
`define SFIL_T1_US        10
`define SFIL_T2_US        150
`define SFIL_T3_US        2500
`define SFIL_T4_US        40000
`define SFIL_LONG_US      40000
`define SFIL_CYC(us)      ((us) * `SFIL_CLK_MHZ)
// the same counts sized to the counter width, so no bits are dropped
`define SFIL_T1_CYC       22'h00_03e8
`define SFIL_T2_CYC       22'h00_3a98
`define SFIL_T3_CYC       22'h03_d090
`define SFIL_T4_CYC       22'h3d_0900
`define SFIL_LONG_CYC     22'h3d_0900
`define SFIL_CNT_W        22
`endif

// >>> logic/sfil_persist.v
// per-condition persistence filter producing one live condition bit
`default_nettype none
`include "sfil_regs.vh"
module sfil_persist #(
	parameter [21:0] T1 = 22'h00_03e8,
	parameter [21:0] T2 = 22'h00_3a98,
	parameter [21:0] T3 = 22'h03_d090,
	parameter [21:0] T4 = 22'h3d_0900
) (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       cond_i,
	input  wire [2:0] filt_i,
	output reg        live_o
);
	reg  [21:0] cnt;
	reg  [21:0] limit;
	always @* begin
		case (filt_i)
			3'h1:    limit = T1;
			3'h2:    limit = T2;
			3'h3:    limit = T3;
			3'h4:    limit = T4;
			default: limit = 22'h00_0000;
		endcase
	end
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt    <= 22'h00_0000;
			live_o <= 1'b0;
		end else if (!cond_i) begin
			cnt    <= 22'h00_0000;
			live_o <= 1'b0;
		end else if (cnt + 22'h00_0001 >= limit) begin
			live_o <= 1'b1;
		end else begin
			cnt <= cnt + 22'h00_0001;
		end
	end
endmodule
`default_nettype wire

// >>> logic/sfil_stretch.v
// holds the interrupt request for a fixed time after it falls
`default_nettype none
module sfil_stretch #(
	parameter [21:0] HOLD = 22'h3d_0900
) (
	input  wire clk_i,
	input  wire rst_i,
	input  wire en_i,
	input  wire req_i,
	output wire out_o
);
	reg  [21:0] cnt;
	always @(posedge clk_i) begin
		if (rst_i)
			cnt <= 22'h00_0000;
		else if (req_i)
			cnt <= HOLD;
		else if (!en_i)
			cnt <= 22'h00_0000;
		else if (cnt != 22'h00_0000)
			cnt <= cnt - 22'h00_0001;
	end
	assign out_o = req_i | (en_i & (cnt != 22'h00_0000));
endmodule
`default_nettype wire

// >>> logic/sfil_top.v
// status and fault logic with a classic wishbone register slave
//
// Contract
// - each live condition sets its sticky bit, which stays until cleared.
// - writing zero to a sticky bit clears that bit alone.
// - writing one to a sticky bit leaves it unchanged.
// - condition bits sit at fixed positions 0 to 7 in all status registers.
// - select bit zero routes the live bit, one routes the sticky bit.
// - a selected active bit with interrupt enable one asserts the interrupt.
// - a selected active bit with output disable one tristates the outputs.
// - a read-only fatal register holds checksum, double-bit, internal errors.
// - any fatal error stops the interpolator until power is cycled.
// - any fatal error asserts the interrupt and tristates the outputs.
// - a live bit follows its condition and clears when it ends.
// - a condition must persist for the configured filter time to set live.
// - the long bit extends the interrupt by 40 ms after it ends.
//
// Register access over Wishbone was left to the implementer.
`default_nettype none
`include "sfil_regs.vh"
module sfil_top #(
	parameter [21:0] T1_CYC   = `SFIL_T1_CYC,
	parameter [21:0] T2_CYC   = `SFIL_T2_CYC,
	parameter [21:0] T3_CYC   = `SFIL_T3_CYC,
	parameter [21:0] T4_CYC   = `SFIL_T4_CYC,
	parameter [21:0] LONG_CYC = `SFIL_LONG_CYC
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [17:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire [7:0]  cond_raw_i,
	input  wire        nvm_checksum_error_i,
	input  wire        nvm_double_bit_error_i,
	input  wire        internal_error_i,
	output reg         interrupt_out_n_o,
	output reg         outputs_hiz_o,
	output reg         interp_halt_o
);
	reg  [5:0]  cfg;
	reg  [7:0]  condition_source_select;
	reg  [7:0]  condition_interrupt_enable;
	reg  [7:0]  condition_output_disable;
	reg  [7:0]  sticky_conditions;
	reg  [2:0]  fatal_errors;
	wire [7:0]  live_conditions;
	wire [7:0]  selected;
	wire        fatal_any;
	wire        irq_req;
	wire        irq_ext;
	wire        hiz_req;
	wire [15:0] idx;
	wire        req;
	wire        wr;
	reg  [7:0]  rd_byte;

	genvar g;
	generate
		for (g = 0; g < `SFIL_NCOND; g = g + 1) begin : g_cond
			sfil_persist #(
				.T1 (T1_CYC),
				.T2 (T2_CYC),
				.T3 (T3_CYC),
				.T4 (T4_CYC)
			) u_persist (
				.clk_i  (clk_i),
				.rst_i  (rst_i),
				.cond_i (cond_raw_i[g]),
				.filt_i (cfg[`SFIL_CFG_FILT_MSB:`SFIL_CFG_FILT_LSB]),
				.live_o (live_conditions[g])
			);
			assign selected[g] = condition_source_select[g] ?
				sticky_conditions[g] : live_conditions[g];
		end
	endgenerate

	// bus: byte address is index times four, single cycle ack
	assign idx = wb_adr_i[17:2];
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr  = req & wb_we_i & wb_sel_i[0];

	always @* begin
		case (idx)
			`SFIL_IDX_CFG:   rd_byte = {2'h0, cfg};
			`SFIL_IDX_SEL:   rd_byte = condition_source_select;
			`SFIL_IDX_IE:    rd_byte = condition_interrupt_enable;
			`SFIL_IDX_HIZ:   rd_byte = condition_output_disable;
			`SFIL_IDX_LIVE:  rd_byte = live_conditions;
			`SFIL_IDX_LATCH: rd_byte = sticky_conditions;
			`SFIL_IDX_FATAL: rd_byte = {5'h00, fatal_errors};
			default:         rd_byte = 8'h00;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			if (req && !wb_we_i)
				wb_dat_o <= {24'h00_0000, rd_byte};
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			cfg                        <= 6'h00;
			condition_source_select    <= 8'h00;
			condition_interrupt_enable <= 8'h00;
			condition_output_disable   <= 8'h00;
		end else if (wr) begin
			case (idx)
				`SFIL_IDX_CFG: cfg <= wb_dat_i[5:0];
				`SFIL_IDX_SEL: condition_source_select <= wb_dat_i[7:0];
				`SFIL_IDX_IE:  condition_interrupt_enable <= wb_dat_i[7:0];
				`SFIL_IDX_HIZ: condition_output_disable <= wb_dat_i[7:0];
				default:       cfg <= cfg;
			endcase
		end
	end

	// set wins over the clearing write
	always @(posedge clk_i) begin
		if (rst_i)
			sticky_conditions <= 8'h00;
		else if (wr && idx == `SFIL_IDX_LATCH)
			sticky_conditions <= (sticky_conditions & wb_dat_i[7:0])
				| live_conditions;
		else
			sticky_conditions <= sticky_conditions | live_conditions;
	end

	// fatal flags are sticky until reset; no write path reaches them
	always @(posedge clk_i) begin
		if (rst_i)
			fatal_errors <= 3'h0;
		else
			fatal_errors <= fatal_errors | {internal_error_i,
				nvm_double_bit_error_i, nvm_checksum_error_i};
	end
	assign fatal_any = |fatal_errors;

	assign irq_req = |(selected & condition_interrupt_enable);
	assign hiz_req = |(selected & condition_output_disable);

	sfil_stretch #(
		.HOLD (LONG_CYC)
	) u_stretch (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.en_i  (cfg[`SFIL_CFG_LONG]),
		.req_i (irq_req | fatal_any),
		.out_o (irq_ext)
	);

	always @(posedge clk_i) begin
		if (rst_i) begin
			interrupt_out_n_o <= 1'b1;
			outputs_hiz_o     <= 1'b0;
			interp_halt_o     <= 1'b0;
		end else begin
			interrupt_out_n_o <= ~irq_ext;
			outputs_hiz_o     <= hiz_req | fatal_any;
			interp_halt_o     <= fatal_any;
		end
	end
endmodule
`default_nettype wire

// >>> verification/sfil_chk_assertions.sv
// checker of answer timing and fatal handling at the top ports
`default_nettype none
module sfil_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic        nvm_checksum_error_i,
	input wire logic        nvm_double_bit_error_i,
	input wire logic        internal_error_i,
	input wire logic        interrupt_out_n_o,
	input wire logic        outputs_hiz_o,
	input wire logic        interp_halt_o
);
	wire logic f = nvm_checksum_error_i | nvm_double_bit_error_i |
		internal_error_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o)
		else $error("request not answered");
	chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	chk_fatal_irq: assert property (f |-> ##2 !interrupt_out_n_o)
		else $error("fatal without interrupt");
	chk_fatal_hiz: assert property (f |-> ##2 outputs_hiz_o)
		else $error("fatal without tristate");
	chk_fatal_halt: assert property (f |-> ##2 interp_halt_o)
		else $error("fatal without halt");
	chk_halt_held: assert property (interp_halt_o |=> interp_halt_o)
		else $error("halt released");
	chk_halt_outputs: assert property (interp_halt_o
		|-> !interrupt_out_n_o && outputs_hiz_o)
		else $error("halt outputs wrong");
	cover property (f);
	cover property ($fell(interrupt_out_n_o));
	cover property (outputs_hiz_o && !interp_halt_o);
endmodule
bind sfil_top sfil_chk sfil_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .wb_dat_o, .nvm_checksum_error_i, .nvm_double_bit_error_i,
	.internal_error_i, .interrupt_out_n_o, .outputs_hiz_o, .interp_halt_o);
`default_nettype wire

// >>> verification/sfil_host.sv
// host side: samples the active-low interrupt line
`default_nettype none
module sfil_host (
	input  wire logic clk_i,
	input  wire logic irq_n_i,
	output var  logic seen_o
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge clk_i) seen_o <= !irq_n_i;
endmodule
`default_nettype wire

// >>> verification/sfil_top_tb.sv
// self-checking bench of the status and fault logic
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module sfil_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic ack, irq_n, hiz, halt, seen;
	logic [17:0] adr = 0;
	logic [31:0] dat = 0, q;
	logic [7:0]  cond = 0, r;
	logic [3:0]  sel = 4'h1;
	logic [2:0]  fat = 0;
	int failures = 0, check_count = 0;
	always #5 clk_i = ~clk_i;
	// short counts keep the run brief
	sfil_top #(.T1_CYC(22'h00_0004), .T2_CYC(22'h00_0008),
		.T3_CYC(22'h00_0010), .T4_CYC(22'h00_0020), .LONG_CYC(22'h00_0014))
	sfil_top_inst (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(q), .wb_ack_o(ack), .cond_raw_i(cond),
		.nvm_checksum_error_i(fat[0]), .nvm_double_bit_error_i(fat[1]),
		.internal_error_i(fat[2]), .interrupt_out_n_o(irq_n),
		.outputs_hiz_o(hiz), .interp_halt_o(halt));
	sfil_host sfil_host_inst (.clk_i, .irq_n_i(irq_n), .seen_o(seen));
	task automatic tally_and_finish;
		if (failures == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= {i, 2'b00};
		dat <= {24'h00_0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		r = q[7:0];
		cyc <= 0;
		stb <= 0;
		if (n >= 50) begin
			failures++;
			tally_and_finish();
		end
	endtask
	task automatic rd(input logic [15:0] i, input logic [7:0] e);
		acc(0, i, 8'h00);
		`CHK(r, e)
	endtask
	initial begin
		wt(20);
		rst_i <= 0;
		for (int k = 0; k < 7; k++) rd(16'h0401 + k, 8'h00);
		acc(1, 16'h0402, 8'ha5);
		sel <= 4'h0;
		acc(1, 16'h0402, 8'hff);
		sel <= 4'h1;
		rd(16'h0402, 8'ha5);
		acc(1, 16'h0404, 8'hff);
		rd(16'h0404, 8'h00);
		cond <= 8'h81;
		wt(3);
		rd(16'h0404, 8'h81);
		cond <= 8'h00;
		wt(3);
		rd(16'h0404, 8'h00);
		rd(16'h0405, 8'h81);
		acc(1, 16'h0405, 8'hfe);
		rd(16'h0405, 8'h80);
		cond <= 8'h80;
		acc(1, 16'h0405, 8'h00);
		rd(16'h0405, 8'h80);
		cond <= 8'h00;
		acc(1, 16'h0405, 8'h00);
		rd(16'h0405, 8'h00);
		for (int i = 0; i < 8; i++) begin
			acc(1, 16'h0402, 8'h01 << i);
			acc(1, 16'h0401, 8'h00);
			cond <= 8'h01 << i;
			wt(1);
			cond <= 8'h00;
			wt(3);
			`CHK(irq_n, 1'b1)
			acc(1, 16'h0401, 8'h01 << i);
			wt(2);
			`CHK({irq_n, hiz}, 2'b00)
			acc(1, 16'h0402, 8'h00);
			acc(1, 16'h0403, 8'h01 << i);
			wt(2);
			`CHK({irq_n, hiz}, 2'b11)
			rd(16'h0405, 8'h01 << i);
			acc(1, 16'h0403, 8'h00);
			acc(1, 16'h0405, 8'h00);
		end
		for (int c = 1; c < 5; c++) begin
			acc(1, 16'h0400, c[7:0]);
			cond <= 8'h01;
			rd(16'h0404, 8'h00);
			wt(4 << c);
			rd(16'h0404, 8'h01);
			cond <= 8'h00;
			wt(3);
		end
		// reserved filter code acts as no filter
		acc(1, 16'h0400, 8'h05);
		cond <= 8'h01;
		wt(3);
		rd(16'h0404, 8'h01);
		cond <= 8'h00;
		wt(3);
		acc(1, 16'h0400, 8'h08);
		acc(1, 16'h0401, 8'h00);
		acc(1, 16'h0402, 8'h01);
		cond <= 8'h01;
		// host flop lags the interrupt pin by one edge
		wt(4);
		`CHK(seen, 1'b1)
		cond <= 8'h00;
		wt(12);
		`CHK(irq_n, 1'b0)
		wt(15);
		`CHK(irq_n, 1'b1)
		for (int k = 0; k < 3; k++) begin
			rst_i <= 1;
			wt(20);
			rst_i <= 0;
			fat <= 3'h1 << k;
			wt(1);
			fat <= 3'h0;
			wt(3);
			`CHK({halt, irq_n, hiz}, 3'b101)
			rd(16'h0406, 8'h01 << k);
			acc(1, 16'h0406, 8'h00);
			rd(16'h0406, 8'h01 << k);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
